// ==== core/fprc_top.sv ====
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module fprc_top
    import fprc_pkg::*;
#(
    parameter int unsigned DEB_LEN = DEB_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // backplane and processor
    input  wire logic        phase2_clk,
    input  wire logic        proc_sync,
    input  wire logic        processor_read_strobe,
    input  wire logic        write_strobe_n,
    input  wire logic [15:0] addr_bus,
    input  wire logic [7:0]  status_bus,
    input  wire logic        int_enabled,
    input  wire logic        wait_state,
    input  wire logic        hold_ack,
    input  wire logic [7:0]  data_bus_in,
    output logic      [7:0]  data_bus_out,
    output logic      [7:0]  data_bus_oe_n,
    output logic             x_ready,
    // panel switches and lamps
    input  wire logic [15:0] addr_switch,
    input  wire logic        run_switch,
    input  wire logic        examine_switch,
    output logic             run_ind,
    output logic      [15:0] addr_ind,
    output logic      [7:0]  status_ind,
    output logic      [7:0]  data_ind,
    output logic      [7:0]  prog_out_ind,
    output logic             int_enabled_ind,
    output logic             wait_ind,
    output logic             hold_ind
);
    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n_s;
    // async assert, release after two edges
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n_s = rst_sync_reg[1];

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    localparam int PIN_W = 57;
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1_reg;
    logic [PIN_W-1:0] pin_s2_reg;
    logic             phi2_d_reg;
    logic             rd_d_reg;
    logic             wr_d_reg;
    logic             phi2_s, sync_s, rd_s, wr_s;
    logic [15:0]      addr_s;
    logic [7:0]       stat_s, db_s;
    logic [17:0]      sw_s;
    logic             inte_s, wait_s, hold_s;
    assign pin_raw = {phase2_clk, proc_sync, processor_read_strobe, ~write_strobe_n,
                      addr_bus, status_bus, data_bus_in, int_enabled, wait_state,
                      hold_ack, addr_switch, run_switch, examine_switch};
    assign {phi2_s, sync_s, rd_s, wr_s, addr_s, stat_s, db_s, inte_s, wait_s,
            hold_s, sw_s} = pin_s2_reg;
    // edge detectors look only at the second stage and its delay
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            phi2_d_reg <= 1'b0;
            rd_d_reg   <= 1'b0;
            wr_d_reg   <= 1'b0;
        end else begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            phi2_d_reg <= phi2_s;
            rd_d_reg   <= rd_s;
            wr_d_reg   <= wr_s;
        end
    end
    logic phi2_fall, rd_fall, wr_rise;
    assign phi2_fall = phi2_d_reg & ~phi2_s;
    assign rd_fall   = rd_d_reg & ~rd_s;
    assign wr_rise   = wr_s & ~wr_d_reg;

    // ---------------------------------------------------------------
    // switch debounce
    // ---------------------------------------------------------------
    logic [17:0]      deb_sw_reg, deb_sw_next;
    logic [DEB_W-1:0] deb_cnt_reg, deb_cnt_next;
    // one shared counter: a bouncing switch restarts the whole window
    always_comb begin
        deb_sw_next  = deb_sw_reg;
        deb_cnt_next = '0;
        if (sw_s != deb_sw_reg) begin
            if (deb_cnt_reg == DEB_W'(DEB_LEN - 1)) begin
                deb_sw_next = sw_s;
            end else begin
                deb_cnt_next = deb_cnt_reg + 1'b1;
            end
        end
    end
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            deb_sw_reg  <= '0;
            deb_cnt_reg <= '0;
        end else begin
            deb_sw_reg  <= deb_sw_next;
            deb_cnt_reg <= deb_cnt_next;
        end
    end
    logic [15:0] dsw_addr;
    logic        dsw_run, dsw_exam, dsw_exam_d_reg;
    assign {dsw_addr, dsw_run, dsw_exam} = deb_sw_reg;

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    logic [2:0]  ctrl_reg, ctrl_next;
    logic        pready_next, pslverr_next;
    logic [31:0] prdata_next;
    logic        apb_wr, exam_soft;
    logic [7:0]  prog_reg;
    logic        run_reg;
    logic [1:0]  exam_cnt_reg;
    logic        x_ready_reg;
    assign apb_wr    = psel & penable & pready & pwrite & ~pslverr;
    assign exam_soft = apb_wr & (paddr[3:0] == REG_CTRL_OFS) & pwdata[CTRL_EXAM_BIT];
    // answer in the second access cycle; unmapped addresses give an error
    always_comb begin
        ctrl_next    = ctrl_reg;
        pready_next  = psel & penable & ~pready;
        pslverr_next = 1'b0;
        prdata_next  = '0;
        if (apb_wr && paddr[3:0] == REG_CTRL_OFS) begin
            ctrl_next = {1'b0, pwdata[CTRL_RUN_BIT], pwdata[CTRL_LOCK_BIT]};
        end
        if (psel && penable && !pready) begin
            if (paddr[31:4] != 28'h0 || paddr[1:0] != 2'h0) begin
                pslverr_next = 1'b1;
            end else begin
                unique case (paddr[3:0])
                    REG_CTRL_OFS:   prdata_next = {29'h0, ctrl_reg};
                    REG_STATUS_OFS: prdata_next = {28'h0, x_ready_reg, exam_cnt_reg, run_reg};
                    REG_SWITCH_OFS: prdata_next = {14'h0, deb_sw_reg};
                    REG_PROG_OFS:   prdata_next = {24'h0, prog_reg};
                    default:        pslverr_next = 1'b1;
                endcase
            end
        end
    end
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ctrl_reg <= CTRL_RESET;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            pready   <= pready_next;
            pslverr  <= pslverr_next;
            prdata   <= prdata_next;
        end
    end

    // ---------------------------------------------------------------
    // run/stop and examine sequencing
    // ---------------------------------------------------------------
    logic       run_sel, exam_start, run_next, x_ready_next;
    logic [1:0] exam_cnt_next;
    // lock hands run and examine over to software; the examine pulse looks at the
    // lock being written, so one write can both take over and start an examine
    assign run_sel    = ctrl_reg[CTRL_LOCK_BIT] ? ctrl_reg[CTRL_RUN_BIT] : dsw_run;
    assign exam_start = ctrl_next[CTRL_LOCK_BIT] ? exam_soft : (dsw_exam & ~dsw_exam_d_reg);
    always_comb begin
        run_next      = run_reg;
        exam_cnt_next = exam_cnt_reg;
        if (run_sel && phi2_fall) begin
            run_next = 1'b1;
        end else if (!run_sel && phi2_s && stat_s[ST_FETCH_BIT] && sync_s) begin
            run_next = 1'b0;
        end
        // examine only starts from a halted processor
        if (exam_cnt_reg == EXAM_IDLE) begin
            if (exam_start && !run_reg) begin
                exam_cnt_next = EXAM_JUMP;
            end
        end else if (rd_fall) begin
            exam_cnt_next = exam_cnt_reg + 2'h1;
        end
        x_ready_next = run_next | (exam_cnt_next != EXAM_IDLE);
    end
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            run_reg        <= 1'b0;
            exam_cnt_reg   <= EXAM_IDLE;
            x_ready_reg    <= 1'b0;
            dsw_exam_d_reg <= 1'b0;
        end else begin
            run_reg        <= run_next;
            exam_cnt_reg   <= exam_cnt_next;
            x_ready_reg    <= x_ready_next;
            dsw_exam_d_reg <= dsw_exam;
        end
    end

    // ---------------------------------------------------------------
    // data bus drive, port, indicators
    // ---------------------------------------------------------------
    logic       port_hit, port_rd, port_wr, inj_en;
    logic [7:0] inj_byte, oe_n_next, prog_next;
    logic [7:0] oe_n_reg, data_ind_reg, stat_ind_reg;
    logic [15:0] addr_ind_reg;
    logic [3:0] misc_ind_reg;
    assign port_hit = addr_s[7:0] == PANEL_PORT;
    assign port_rd  = port_hit & stat_s[ST_INP_BIT] & rd_s;
    assign port_wr  = port_hit & stat_s[ST_OUT_BIT];
    // examine bytes take priority over the port read
    always_comb begin
        inj_en   = rd_s & (exam_cnt_reg != EXAM_IDLE | port_rd);
        unique case (exam_cnt_reg)
            EXAM_JUMP: inj_byte = INSTR_JUMP;
            EXAM_LOW:  inj_byte = dsw_addr[7:0];
            EXAM_HIGH: inj_byte = dsw_addr[15:8];
            EXAM_IDLE: inj_byte = dsw_addr[15:8];
        endcase
        // open drain: only zeros are driven, ones float to the pull-up
        oe_n_next = ~({8{inj_en}} & ~inj_byte);
        prog_next = (wr_rise && port_wr) ? db_s : prog_reg;
    end
    always_ff @(posedge core_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            oe_n_reg     <= 8'hff;
            prog_reg     <= PROG_RESET;
            data_ind_reg <= 8'h00;
            addr_ind_reg <= 16'h0000;
            stat_ind_reg <= 8'h00;
            misc_ind_reg <= 4'h0;
        end else begin
            oe_n_reg     <= oe_n_next;
            prog_reg     <= prog_next;
            data_ind_reg <= db_s;
            addr_ind_reg <= addr_s;
            stat_ind_reg <= stat_s;
            misc_ind_reg <= {run_next, inte_s, wait_s, hold_s};
        end
    end
    assign data_bus_out  = 8'h00;
    assign data_bus_oe_n = oe_n_reg;
    assign x_ready       = x_ready_reg;
    assign prog_out_ind  = prog_reg;
    assign data_ind      = data_ind_reg;
    assign addr_ind      = addr_ind_reg;
    assign status_ind    = stat_ind_reg;
    assign {run_ind, int_enabled_ind, wait_ind, hold_ind} = misc_ind_reg;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n_s);
    a_run_set: assert property (run_sel && phi2_fall |=> run_reg)
        else $error("run flop not set on phase two fall");
    a_run_clear: assert property (!run_sel && phi2_s && stat_s[ST_FETCH_BIT] && sync_s
        |=> !run_reg && !run_ind)
        else $error("run flop not cleared at fetch sync");
    a_run_lamp: assert property (run_ind == run_reg)
        else $error("run lamp differs from run flop");
    a_ready_src: assert property (x_ready == (run_reg || exam_cnt_reg != EXAM_IDLE))
        else $error("ready not from run or examine");
    a_exam_jump: assert property (exam_cnt_reg == EXAM_JUMP && rd_s
        |=> data_bus_oe_n == INSTR_JUMP)
        else $error("jump opcode not driven");
    a_exam_high: assert property (exam_cnt_reg == EXAM_HIGH && rd_s
        |=> data_bus_oe_n == $past(dsw_addr[15:8]))
        else $error("high address byte not driven");
    a_exam_stop: assert property (exam_cnt_reg == EXAM_HIGH && rd_fall && !run_reg
        ##0 run_next == 1'b0 |=> exam_cnt_reg == EXAM_IDLE && !x_ready)
        else $error("no halt after examine");
    a_bus_quiet: assert property (!rd_s |=> data_bus_oe_n == 8'hff)
        else $error("bus driven outside read strobe");
    a_port_read: assert property (port_rd && exam_cnt_reg == EXAM_IDLE
        |=> data_bus_oe_n == $past(dsw_addr[15:8]))
        else $error("port read byte wrong");
    a_latch_load: assert property (wr_rise && port_wr |=> prog_out_ind == $past(db_s))
        else $error("output latch not loaded");
    a_data_lamp: assert property (##1 data_ind == $past(db_s))
        else $error("data lamps lag wrong");
    a_deb_hold: assert property ($changed(deb_sw_reg)
        |-> $past(deb_cnt_reg) == DEB_W'(DEB_LEN - 1))
        else $error("switch accepted before debounce");
    c_run_start: cover property (!run_reg ##1 run_reg);
    c_exam_full: cover property (exam_cnt_reg == EXAM_HIGH ##[1:200] exam_cnt_reg == EXAM_IDLE);
    c_port_read: cover property (port_rd && exam_cnt_reg == EXAM_IDLE);
    c_latch: cover property (wr_rise && port_wr);
endmodule : fprc_top

// ==== core/fprc_pkg.sv ====
package fprc_pkg;
    // ---------------------------------------------------------------
    // apb register map
    // ---------------------------------------------------------------
    localparam logic [3:0]  REG_CTRL_OFS   = 4'h0;
    localparam logic [3:0]  REG_STATUS_OFS = 4'h4;
    localparam logic [3:0]  REG_SWITCH_OFS = 4'h8;
    localparam logic [3:0]  REG_PROG_OFS   = 4'hc;
    localparam int          CTRL_LOCK_BIT  = 0;
    localparam int          CTRL_RUN_BIT   = 1;
    localparam int          CTRL_EXAM_BIT  = 2;
    localparam logic [2:0]  CTRL_RESET     = 3'h0;
    localparam logic [7:0]  PROG_RESET     = 8'h00;
    // ---------------------------------------------------------------
    // processor bus encodings
    // ---------------------------------------------------------------
    localparam logic [7:0]  INSTR_JUMP     = 8'hc3;
    localparam logic [7:0]  PANEL_PORT     = 8'hff;
    localparam int          ST_OUT_BIT     = 4;
    localparam int          ST_FETCH_BIT   = 5;
    localparam int          ST_INP_BIT     = 6;
    localparam logic [1:0]  EXAM_IDLE      = 2'h0;
    localparam logic [1:0]  EXAM_JUMP      = 2'h1;
    localparam logic [1:0]  EXAM_LOW       = 2'h2;
    localparam logic [1:0]  EXAM_HIGH      = 2'h3;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int          CLK_MHZ        = 250;
    localparam int          DEB_TIME_US    = 1000;
    localparam int          DEB_CYCLES     = DEB_TIME_US * CLK_MHZ;
    localparam int          DEB_W          = 20;
endpackage : fprc_pkg

// ==== sim/fprc_proc_model.sv ====
`timescale 1ns/1ps
// -----------------------------------------------------------------
// processor board: free phase-two clock, bus cycles, wired-and bus
// -----------------------------------------------------------------
module fprc_proc_model (
    input  wire logic        core_clk,
    input  wire logic [7:0]  data_bus_out,
    input  wire logic [7:0]  data_bus_oe_n,
    output logic             phase2_clk,
    output logic             proc_sync,
    output logic             processor_read_strobe,
    output logic             write_strobe_n,
    output logic      [15:0] addr_bus,
    output logic      [7:0]  status_bus,
    output logic      [7:0]  data_bus_in
);
    logic [7:0] drv_reg = 8'hff;
    int         ph      = 0;

    initial begin
        phase2_clk = 1'b0;
        proc_sync = 1'b0;
        processor_read_strobe = 1'b0;
        write_strobe_n = 1'b1;
        addr_bus = 16'h0000;
        status_bus = 8'h00;
    end

    // pull-ups hold each line high unless either party sinks it
    assign data_bus_in = drv_reg & (data_bus_oe_n | data_bus_out);

    // phase two runs free, ten core cycles per period
    always @(posedge core_clk) begin
        ph <= (ph == 4) ? 0 : ph + 1;
        if (ph == 4) begin
            phase2_clk <= ~phase2_clk;
        end
    end

    // one bus cycle; a read leaves the lines to the panel and pull-ups
    task automatic cycle(input logic [15:0] a, input logic [7:0] st, input logic rd,
                         input logic [7:0] wd, output logic [7:0] seen);
        @(posedge core_clk);
        addr_bus <= a;
        status_bus <= st;
        processor_read_strobe <= rd;
        write_strobe_n <= rd;
        drv_reg <= rd ? 8'hff : wd;
        repeat (6) @(posedge core_clk);
        seen = data_bus_in;
        processor_read_strobe <= 1'b0;
        write_strobe_n <= 1'b1;
        drv_reg <= 8'hff;
        repeat (4) @(posedge core_clk);
    endtask : cycle

    // fetch with sync held over a whole high phase of phase two
    task automatic fetch();
        @(posedge core_clk);
        proc_sync <= 1'b1;
        status_bus <= 8'h20;
        repeat (12) @(posedge core_clk);
        proc_sync <= 1'b0;
        status_bus <= 8'h00;
    endtask : fetch
endmodule : fprc_proc_model

// ==== sim/front_panel_run_control_tb_top.sv ====
`timescale 1ns/1ps
module front_panel_run_control_tb_top import fprc_pkg::*;;
    logic        core_clk = 1'b0;
    logic        rstn     = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [31:0] paddr    = 32'h0;
    logic [31:0] pwdata   = 32'h0;
    logic [15:0] addr_switch    = 16'h5a3c;
    logic        run_switch     = 1'b0;
    logic        examine_switch = 1'b0;
    logic        int_enabled    = 1'b1;
    logic        wait_state     = 1'b1;
    logic        hold_ack       = 1'b0;
    logic [31:0] prdata, rdata;
    logic        pready, pslverr, err, phase2_clk, proc_sync, processor_read_strobe;
    logic        write_strobe_n, x_ready, run_ind, int_enabled_ind, wait_ind, hold_ind;
    logic [15:0] addr_bus, addr_ind;
    logic [7:0]  status_bus, data_bus_in, data_bus_out, data_bus_oe_n, status_ind;
    logic [7:0]  data_ind, prog_out_ind, seen;
    logic [7:0]  exp_b [3];
    int          errors      = 0;
    int          comparisons = 0;

    always #2 core_clk = ~core_clk;

    fprc_top #(.DEB_LEN(4)) fprc_top_inst (.core_clk, .rstn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .phase2_clk, .proc_sync,
        .processor_read_strobe, .write_strobe_n, .addr_bus, .status_bus, .int_enabled,
        .wait_state, .hold_ack, .data_bus_in, .data_bus_out, .data_bus_oe_n, .x_ready,
        .addr_switch, .run_switch, .examine_switch, .run_ind, .addr_ind, .status_ind,
        .data_ind, .prog_out_ind, .int_enabled_ind, .wait_ind, .hold_ind);

    fprc_proc_model fprc_proc_model_inst (.core_clk, .data_bus_out, .data_bus_oe_n,
        .phase2_clk, .proc_sync, .processor_read_strobe, .write_strobe_n, .addr_bus,
        .status_bus, .data_bus_in);

    // -----------------------------------------------------------------
    // checking and bus tasks
    // -----------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // apb master; waits on pready, the watchdog bounds a hang
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] exp);
        apb(1'b0, 32'(a), 32'h0, rdata, err);
        check(nm, rdata, exp);
    endtask : rd_chk

    // with the switch in control, the run indicator sets only after debounce and a phase-two fall
    task automatic wait_run(input logic v);
        repeat (60) begin
            @(posedge core_clk);
            if (run_ind === v) break;
        end
    endtask : wait_run

    task automatic close_out();
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        exp_b = '{INSTR_JUMP, 8'h3c, 8'h5a};
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd_chk("ctrl", REG_CTRL_OFS, 32'(CTRL_RESET));
        rd_chk("prog", REG_PROG_OFS, 32'(PROG_RESET));
        rd_chk("switch", REG_SWITCH_OFS, 32'h000168f0);
        apb(1'b0, 32'h10, 32'h0, rdata, err);
        check("unmapped err", 32'(err), 32'h1);
        apb(1'b1, 32'h2, 32'h7, rdata, err);
        check("misaligned err", 32'(err), 32'h1);
        check("int_ind", 32'({int_enabled_ind, wait_ind, hold_ind}), 32'h6);
        // port write, with lamps watched mid-cycle
        fork
            fprc_proc_model_inst.cycle(16'hffff, 8'h10, 1'b0, 8'ha5, seen);
            begin
                repeat (6) @(posedge core_clk);
                check("addr_ind", 32'(addr_ind), 32'hffff);
                check("status_ind", 32'(status_ind), 32'h10);
                check("data_ind", 32'(data_ind), 32'ha5);
            end
        join
        check("prog_out", 32'(prog_out_ind), 32'ha5);
        rd_chk("prog", REG_PROG_OFS, 32'ha5);
        fprc_proc_model_inst.cycle(16'hfefe, 8'h10, 1'b0, 8'h3c, seen);
        fprc_proc_model_inst.cycle(16'hffff, 8'h00, 1'b0, 8'h3c, seen);
        check("prog_out kept", 32'(prog_out_ind), 32'ha5);
        // port read: only port ff with input status
        fprc_proc_model_inst.cycle(16'hffff, 8'h40, 1'b1, 8'h00, seen);
        check("port read", 32'(seen), 32'h5a);
        fprc_proc_model_inst.cycle(16'hfefe, 8'h40, 1'b1, 8'h00, seen);
        check("other port", 32'(seen), 32'hff);
        fprc_proc_model_inst.cycle(16'hffff, 8'h80, 1'b1, 8'h00, seen);
        check("mem read", 32'(seen), 32'hff);
        // a short bounce must not start the processor
        run_switch <= 1'b1;
        repeat (2) @(posedge core_clk);
        run_switch <= 1'b0;
        repeat (40) @(posedge core_clk);
        check("glitch", 32'(run_ind), 32'h0);
        run_switch <= 1'b1;
        wait_run(1'b1);
        check("run_ind", 32'(run_ind), 32'h1);
        check("x_ready", 32'(x_ready), 32'h1);
        rd_chk("status", REG_STATUS_OFS, 32'h9);
        // stop waits for a fetch with sync
        run_switch <= 1'b0;
        repeat (40) @(posedge core_clk);
        check("stop early", 32'(run_ind), 32'h1);
        fprc_proc_model_inst.fetch();
        repeat (4) @(posedge core_clk);
        check("stopped", 32'({run_ind, x_ready}), 32'h0);
        // examine from the switch, then from software
        for (int k = 0; k < 2; k++) begin
            if (k == 0) begin
                examine_switch <= 1'b1;
                repeat (20) @(posedge core_clk);
                examine_switch <= 1'b0;
            end else begin
                apb(1'b1, 32'(REG_CTRL_OFS), 32'h5, rdata, err);
            end
            repeat (4) @(posedge core_clk);
            check("exam ready", 32'(x_ready), 32'h1);
            check("bus idle", 32'(data_bus_in), 32'hff);
            for (int b = 0; b < 3; b++) begin
                fprc_proc_model_inst.cycle(16'h0100, 8'h80, 1'b1, 8'h00, seen);
                check("exam byte", 32'(seen), 32'(exp_b[b]));
            end
            check("exam halt", 32'(x_ready), 32'h0);
        end
        rd_chk("status", REG_STATUS_OFS, 32'h0);
        rd_chk("ctrl", REG_CTRL_OFS, 32'h1);
        close_out();
    end

    // watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        close_out();
    end
endmodule : front_panel_run_control_tb_top
